// ### common/can_rx_pkg.sv
// constants, register map and filter helpers of the CAN receive path
// assumes an 8-bit register port and an external protocol engine feeding bytes
package can_rx_pkg;

  localparam int DATA_W     = 8;
  localparam int ADDR_W     = 8;
  localparam int NUM_FIFO   = 5;
  localparam int NUM_SLOTS  = 6;
  localparam int SLOT_BYTES = 16;
  localparam int MEM_AW     = 7;
  localparam int CNT_W      = 3;
  localparam int SLOT_W     = 3;

  localparam logic [3:0] BUF_BYTES    = 4'hF;
  localparam logic [3:0] FRAME_BYTES  = 4'hD;
  localparam logic [3:0] ID_BYTES     = 4'h4;
  localparam logic [3:0] STAMP_HI_IDX = 4'hD;
  localparam logic [3:0] STAMP_LO_IDX = 4'hE;

  localparam logic [7:0] OFS_CTL0  = 8'h00;
  localparam logic [7:0] OFS_CTL1  = 8'h01;
  localparam logic [7:0] OFS_BTR0  = 8'h02;
  localparam logic [7:0] OFS_BTR1  = 8'h03;
  localparam logic [7:0] OFS_RFLG  = 8'h04;
  localparam logic [7:0] OFS_RIER  = 8'h05;
  localparam logic [7:0] OFS_IDAC  = 8'h0B;
  localparam logic [7:0] OFS_RXERR = 8'h0E;
  localparam logic [7:0] OFS_TXERR = 8'h0F;
  localparam logic [7:0] OFS_PAT   = 8'h10;
  localparam logic [7:0] OFS_MASK  = 8'h18;
  localparam logic [7:0] OFS_FG    = 8'h20;
  localparam logic [7:0] OFS_BANK_END = 8'h20;

  localparam int CTL0_INIT_REQUEST_BIT = 0;
  localparam int CTL0_TIME_BIT   = 3;
  localparam int CTL1_INIT_ACKNOWLEDGE_BIT = 0;
  localparam int CTL1_LOOPB_BIT  = 5;
  localparam int CTL1_ENABLE_BIT = 7;
  localparam int RFLG_RXF_BIT    = 0;
  localparam int RFLG_OVR_BIT    = 1;
  localparam int IDAC_MODE_LSB   = 4;

  localparam logic [7:0] CTL0_RST = 8'h01;
  localparam logic [7:0] CTL1_RST = 8'h00;
  localparam logic [7:0] REG_RST  = 8'h00;

  typedef enum logic [1:0] {
    MODE_TWO    = 2'b00,
    MODE_FOUR   = 2'b01,
    MODE_EIGHT  = 2'b10,
    MODE_CLOSED = 2'b11
  } filter_mode_type;

  // mask bit set means the identifier bit is ignored
  function automatic logic byte_match(input logic [7:0] id, input logic [7:0] pat, input logic [7:0] msk);
    byte_match = &((~(id ^ pat)) | msk);
  endfunction

endpackage

// ### rtl/rx_msg_memory.sv
// message storage: all receive slots, one write port, registered read
// assumes the caller keeps the write and read addresses below DEPTH
`timescale 1ns/1ps
`default_nettype none
module rx_msg_memory #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 96,
  parameter int AW    = 7
) (
  input  wire logic             clk,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic             re,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // no reset on the array; reads before a push are masked to zeros by the caller
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (re) begin
      rdata <= mem[raddr];
    end
  end

endmodule
`default_nettype wire

// ### rtl/acceptance_filter.sv
// identifier acceptance filter: two, four or eight maskable filters
// assumes id bytes in receive buffer order, byte 0 in bits 7:0
`timescale 1ns/1ps
`default_nettype none
module acceptance_filter (
  input  wire logic [31:0] id_bytes,
  input  wire logic [63:0] pattern,
  input  wire logic [63:0] mask,
  input  wire logic [1:0]  mode,
  output logic             hit,
  output logic [2:0]       hit_index
);

  logic [7:0] m32;
  logic [7:0] m16;
  logic [7:0] m8;
  logic [7:0] hits;

  always_comb begin
    for (int k = 0; k < 8; k++) begin
      m32[k] = can_rx_pkg::byte_match(id_bytes[8*(k%4)+:8], pattern[8*k+:8], mask[8*k+:8]);
      m16[k] = can_rx_pkg::byte_match(id_bytes[8*(k%2)+:8], pattern[8*k+:8], mask[8*k+:8]);
      m8[k]  = can_rx_pkg::byte_match(id_bytes[7:0], pattern[8*k+:8], mask[8*k+:8]);
    end
  end

  always_comb begin
    hits = 8'h00;
    unique case (mode)
      can_rx_pkg::MODE_TWO: begin
        hits[0] = &m32[3:0];
        hits[1] = &m32[7:4];
      end
      can_rx_pkg::MODE_FOUR: begin
        for (int f = 0; f < 4; f++) begin
          hits[f] = m16[2*f] & m16[2*f+1];
        end
      end
      can_rx_pkg::MODE_EIGHT: begin
        hits = m8;
      end
      can_rx_pkg::MODE_CLOSED: begin
        hits = 8'h00;
      end
    endcase
  end

  // scan downward so the lowest matching filter is left standing
  always_comb begin
    hit_index = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (hits[i]) begin
        hit_index = 3'(i);
      end
    end
    hit = |hits;
  end

endmodule
`default_nettype wire

// ### rtl/can_receive_fifo_filter.sv
// CAN receive path: five-message FIFO, acceptance filter, configuration lock
// assumes a protocol engine that delivers frame bytes, frame end and status
//
// Summary of operation
// - five FIFO buffers plus one background buffer
// - each buffer holds fifteen bytes
// - full flag set when foreground holds accepted message
// - valid accepted frame pushed, flag set, interrupt
// - next frame lands in next free background
// - rejected or errored frame overwritten, never pushed
// - own transmitted frame captured, not pushed, unacknowledged
// - loopback treats own frames like any frame
// - lost arbitration turns device into receiver
// - accepted frame on full FIFO dropped, overrun
// - full FIFO drops frames until slot frees
// - identifier compared to pattern, mask bits ignored
// - three-bit hit index, lowest filter wins
// - two-filter mode uses four-byte banks
// - four-filter mode uses two-byte filters
// - eight-filter mode matches first identifier byte
// - closed mode never fills foreground
// - error counters cannot be written
// - configuration writes only in initialization mode
// - transmit pin recessive in init or power-down
// - module enable written once in normal modes
// - time stamp stored after valid frame end
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module can_receive_fifo_filter (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       rx_frame_start,
  input  wire logic       rx_byte_valid,
  input  wire logic [3:0] rx_byte_index,
  input  wire logic [7:0] rx_byte_data,
  input  wire logic       rx_frame_end,
  input  wire logic       rx_frame_ok,
  input  wire logic       tx_active,
  input  wire logic       arb_lost,
  input  wire logic       tx_bit,
  input  wire logic       bit_tick,
  input  wire logic       power_down,
  input  wire logic       special_mode,
  input  wire logic [7:0] rx_err_count,
  input  wire logic [7:0] tx_err_count,
  output logic            can_transmit_pin,
  output logic            rx_ack_enable,
  output logic            rx_irq,
  output logic            overrun_irq
);

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b001,
    ST_STAMP_HI = 3'b010,
    ST_STAMP_LO = 3'b100
  } stamp_state_type;

  stamp_state_type state_q;

  logic [7:0]  ctl0_q;
  logic [7:0]  ctl1_q;
  logic [7:0]  btr0_q;
  logic [7:0]  btr1_q;
  logic [1:0]  mode_q;
  logic [1:0]  rx_ie_q;
  logic [63:0] pattern_q;
  logic [63:0] mask_q;
  logic        init_ack_q;
  logic        module_enable_q;
  logic        enable_written_q;
  logic        rx_full_flag_q;
  logic        overrun_q;
  logic [15:0] timer_q;
  logic [31:0] id_q;
  logic        own_frame_q;
  logic        pend_accept_q;
  logic [2:0]  pend_hit_q;
  logic [2:0]  wr_ptr_q;
  logic [2:0]  rd_ptr_q;
  logic [2:0]  count_q;
  logic [2:0]  hit_slot_q [can_rx_pkg::NUM_SLOTS];
  logic [7:0]  reg_rdata_q;
  logic        mem_sel_q;
  logic        fg_valid_q;

  logic        filter_hit;
  logic [2:0]  filter_index;
  logic        accept;
  logic        commit;
  logic        commit_accept;
  logic [2:0]  commit_hit;
  logic        fifo_full;
  logic        push;
  logic        pop;
  logic [2:0]  count_d;
  logic        mem_we;
  logic [6:0]  mem_waddr;
  logic [7:0]  mem_wdata;
  logic        mem_re;
  logic [6:0]  mem_raddr;
  logic [7:0]  mem_rdata;
  logic        cfg_open;
  logic        in_init;
  logic        loopback;
  logic        time_en;
  logic [7:0]  fg_off;

  function automatic logic [2:0] next_slot(input logic [2:0] s);
    next_slot = (s == 3'(can_rx_pkg::NUM_SLOTS - 1)) ? 3'h0 : s + 3'h1;
  endfunction

  function automatic logic [6:0] slot_addr(input logic [2:0] s, input logic [3:0] idx);
    slot_addr = {s, idx};
  endfunction

  assign cfg_open = init_ack_q;
  assign in_init  = ctl0_q[can_rx_pkg::CTL0_INIT_REQUEST_BIT] | init_ack_q;
  assign loopback = ctl1_q[can_rx_pkg::CTL1_LOOPB_BIT];
  assign time_en  = ctl0_q[can_rx_pkg::CTL0_TIME_BIT];
  assign fg_off   = addr - can_rx_pkg::OFS_FG;

  acceptance_filter u_filter (
    .id_bytes  (id_q),
    .pattern   (pattern_q),
    .mask      (mask_q),
    .mode      (mode_q),
    .hit       (filter_hit),
    .hit_index (filter_index)
  );

  // own frames only count while loopback is on or arbitration was lost
  assign accept = rx_frame_ok & filter_hit & module_enable_q & ~in_init
                & (~own_frame_q | loopback)
                & (mode_q != can_rx_pkg::MODE_CLOSED);

  always_comb begin
    commit        = 1'b0;
    commit_accept = 1'b0;
    commit_hit    = filter_index;
    if (state_q == ST_STAMP_LO) begin
      commit        = 1'b1;
      commit_accept = pend_accept_q;
      commit_hit    = pend_hit_q;
    end else if (state_q == ST_IDLE && rx_frame_end && !(time_en && rx_frame_ok)) begin
      commit        = 1'b1;
      commit_accept = accept;
    end
  end

  assign pop       = wr && addr == can_rx_pkg::OFS_RFLG && wdata[can_rx_pkg::RFLG_RXF_BIT] && count_q != 3'h0;
  assign fifo_full = count_q == 3'(can_rx_pkg::NUM_FIFO) && !pop;
  assign push      = commit & commit_accept & ~fifo_full;
  assign count_d   = count_q + {2'b00, push} - {2'b00, pop};

  always_comb begin
    mem_we    = 1'b0;
    mem_waddr = slot_addr(wr_ptr_q, rx_byte_index);
    mem_wdata = rx_byte_data;
    unique case (state_q)
      ST_STAMP_HI: begin
        mem_we    = 1'b1;
        mem_waddr = slot_addr(wr_ptr_q, can_rx_pkg::STAMP_HI_IDX);
        mem_wdata = timer_q[15:8];
      end
      ST_STAMP_LO: begin
        mem_we    = 1'b1;
        mem_waddr = slot_addr(wr_ptr_q, can_rx_pkg::STAMP_LO_IDX);
        mem_wdata = timer_q[7:0];
      end
      ST_IDLE: begin
        mem_we = rx_byte_valid && rx_byte_index < can_rx_pkg::FRAME_BYTES;
      end
    endcase
  end

  assign mem_re    = rd && addr >= can_rx_pkg::OFS_FG && fg_off < 8'(can_rx_pkg::BUF_BYTES);
  assign mem_raddr = slot_addr(rd_ptr_q, fg_off[3:0]);

  rx_msg_memory #(
    .WIDTH (can_rx_pkg::DATA_W),
    .DEPTH (can_rx_pkg::NUM_SLOTS * can_rx_pkg::SLOT_BYTES),
    .AW    (can_rx_pkg::MEM_AW)
  ) u_mem (
    .clk   (clk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .re    (mem_re),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q       <= ST_IDLE;
      pend_accept_q <= 1'b0;
      pend_hit_q    <= 3'h0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (rx_frame_end && rx_frame_ok && time_en) begin
            state_q       <= ST_STAMP_HI;
            pend_accept_q <= accept;
            pend_hit_q    <= filter_index;
          end
        end
        ST_STAMP_HI: state_q <= ST_STAMP_LO;
        ST_STAMP_LO: state_q <= ST_IDLE;
      endcase
    end
  end

  // background slot is wr_ptr; a rejected frame simply stays there to be overwritten
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_q <= 3'h0;
      rd_ptr_q <= 3'h0;
      count_q  <= 3'h0;
      for (int i = 0; i < can_rx_pkg::NUM_SLOTS; i++) begin
        hit_slot_q[i] <= 3'h0;
      end
    end else begin
      if (push) begin
        wr_ptr_q             <= next_slot(wr_ptr_q);
        hit_slot_q[wr_ptr_q] <= commit_hit;
      end
      if (pop) begin
        rd_ptr_q <= next_slot(rd_ptr_q);
      end
      count_q <= count_d;
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_full_flag_q <= 1'b0;
      overrun_q      <= 1'b0;
    end else begin
      rx_full_flag_q <= count_d != 3'h0;
      if (commit && commit_accept && fifo_full) begin
        overrun_q <= 1'b1;
      end else if (wr && addr == can_rx_pkg::OFS_RFLG && wdata[can_rx_pkg::RFLG_OVR_BIT]) begin
        overrun_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      id_q        <= 32'h0000_0000;
      own_frame_q <= 1'b0;
    end else begin
      if (state_q == ST_IDLE && rx_byte_valid && rx_byte_index < can_rx_pkg::ID_BYTES) begin
        id_q[8*rx_byte_index[1:0]+:8] <= rx_byte_data;
      end
      if (rx_frame_start) begin
        own_frame_q <= tx_active;
      end else if (arb_lost) begin
        own_frame_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_q <= 16'h0000;
    end else if (init_ack_q) begin
      timer_q <= 16'h0000;
    end else if (bit_tick) begin
      timer_q <= timer_q + 16'h0001;
    end
  end

  // configuration lock: guarded registers only change once init is acknowledged
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl0_q           <= can_rx_pkg::CTL0_RST;
      ctl1_q           <= can_rx_pkg::CTL1_RST;
      btr0_q           <= can_rx_pkg::REG_RST;
      btr1_q           <= can_rx_pkg::REG_RST;
      mode_q           <= 2'b00;
      rx_ie_q          <= 2'b00;
      pattern_q        <= 64'h0000_0000_0000_0000;
      mask_q           <= 64'h0000_0000_0000_0000;
      module_enable_q  <= 1'b0;
      enable_written_q <= 1'b0;
      init_ack_q       <= 1'b0;
    end else begin
      init_ack_q <= ctl0_q[can_rx_pkg::CTL0_INIT_REQUEST_BIT];
      if (wr) begin
        if (addr == can_rx_pkg::OFS_CTL0) begin
          ctl0_q <= wdata;
        end
        if (addr == can_rx_pkg::OFS_CTL1) begin
          if (cfg_open) begin
            ctl1_q <= wdata;
          end
          if (!enable_written_q || special_mode) begin
            module_enable_q  <= wdata[can_rx_pkg::CTL1_ENABLE_BIT];
            enable_written_q <= 1'b1;
          end
        end
        if (addr == can_rx_pkg::OFS_RIER) begin
          rx_ie_q <= wdata[1:0];
        end
        if (cfg_open) begin
          if (addr == can_rx_pkg::OFS_BTR0) begin
            btr0_q <= wdata;
          end
          if (addr == can_rx_pkg::OFS_BTR1) begin
            btr1_q <= wdata;
          end
          if (addr == can_rx_pkg::OFS_IDAC) begin
            mode_q <= wdata[can_rx_pkg::IDAC_MODE_LSB+:2];
          end
          if (addr >= can_rx_pkg::OFS_PAT && addr < can_rx_pkg::OFS_MASK) begin
            pattern_q[8*addr[2:0]+:8] <= wdata;
          end
          if (addr >= can_rx_pkg::OFS_MASK && addr < can_rx_pkg::OFS_BANK_END) begin
            mask_q[8*addr[2:0]+:8] <= wdata;
          end
        end
      end
    end
  end

  // error counters have no write path at all
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_q <= 8'h00;
      mem_sel_q   <= 1'b0;
      fg_valid_q  <= 1'b0;
    end else begin
      mem_sel_q  <= mem_re;
      fg_valid_q <= count_q != 3'h0;
      if (rd) begin
        reg_rdata_q <= 8'h00;
        if (addr == can_rx_pkg::OFS_CTL0) begin
          reg_rdata_q <= ctl0_q;
        end else if (addr == can_rx_pkg::OFS_CTL1) begin
          reg_rdata_q <= {module_enable_q, ctl1_q[6:1], init_ack_q};
        end else if (addr == can_rx_pkg::OFS_BTR0) begin
          reg_rdata_q <= btr0_q;
        end else if (addr == can_rx_pkg::OFS_BTR1) begin
          reg_rdata_q <= btr1_q;
        end else if (addr == can_rx_pkg::OFS_RFLG) begin
          reg_rdata_q <= {6'h00, overrun_q, rx_full_flag_q};
        end else if (addr == can_rx_pkg::OFS_RIER) begin
          reg_rdata_q <= {6'h00, rx_ie_q};
        end else if (addr == can_rx_pkg::OFS_IDAC) begin
          reg_rdata_q <= {2'b00, mode_q, 1'b0, hit_slot_q[rd_ptr_q]};
        end else if (addr == can_rx_pkg::OFS_RXERR) begin
          reg_rdata_q <= rx_err_count;
        end else if (addr == can_rx_pkg::OFS_TXERR) begin
          reg_rdata_q <= tx_err_count;
        end else if (addr >= can_rx_pkg::OFS_PAT && addr < can_rx_pkg::OFS_MASK) begin
          reg_rdata_q <= pattern_q[8*addr[2:0]+:8];
        end else if (addr >= can_rx_pkg::OFS_MASK && addr < can_rx_pkg::OFS_BANK_END) begin
          reg_rdata_q <= mask_q[8*addr[2:0]+:8];
        end
      end
    end
  end

  // memory read data is already a flop; an empty FIFO shows zeros
  assign rdata = mem_sel_q ? (fg_valid_q ? mem_rdata : 8'h00) : reg_rdata_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      can_transmit_pin <= 1'b1;
      rx_ack_enable    <= 1'b0;
      rx_irq           <= 1'b0;
      overrun_irq      <= 1'b0;
    end else begin
      can_transmit_pin <= (in_init || power_down || !module_enable_q) ? 1'b1 : tx_bit;
      rx_ack_enable    <= module_enable_q && !in_init && (!own_frame_q || loopback);
      rx_irq           <= rx_full_flag_q && rx_ie_q[can_rx_pkg::RFLG_RXF_BIT];
      overrun_irq      <= overrun_q && rx_ie_q[can_rx_pkg::RFLG_OVR_BIT];
    end
  end

endmodule
`default_nettype wire

// ### bench/can_frame_source.sv
// protocol engine stand-in: delivers whole frames byte by byte
// assumes the caller starts a frame only after the previous send returned
`timescale 1ns/1ps
`default_nettype none
module can_frame_source (
  input  wire logic       clk,
  output logic            rx_frame_start,
  output logic            rx_byte_valid,
  output logic      [3:0] rx_byte_index,
  output logic      [7:0] rx_byte_data,
  output logic            rx_frame_end,
  output logic            rx_frame_ok,
  output logic            tx_active,
  output logic            arb_lost
);
  initial begin
    rx_frame_start = 1'b0;
    rx_byte_valid  = 1'b0;
    rx_byte_index  = 4'h0;
    rx_byte_data   = 8'h00;
    rx_frame_end   = 1'b0;
    rx_frame_ok    = 1'b0;
    tx_active      = 1'b0;
    arb_lost       = 1'b0;
  end
  task automatic send(input logic [31:0] id, input logic ok, input logic own, input logic lost);
    int i;
    @(posedge clk);
    rx_frame_start <= 1'b1;
    tx_active      <= own;
    @(posedge clk);
    rx_frame_start <= 1'b0;
    for (i = 0; i < 13; i++) begin
      rx_byte_valid <= 1'b1;
      rx_byte_index <= i[3:0];
      rx_byte_data  <= (i < 4) ? id[8*i +: 8] : 8'hA0 + i[7:0];
      arb_lost      <= lost && (i == 2);
      @(posedge clk);
    end
    // stale byte lane inverted so a held value never looks fresh
    rx_byte_valid <= 1'b0;
    rx_byte_data  <= ~rx_byte_data;
    arb_lost      <= 1'b0;
    rx_frame_end  <= 1'b1;
    rx_frame_ok   <= ok;
    @(posedge clk);
    rx_frame_end <= 1'b0;
    rx_frame_ok  <= ~ok;
    tx_active    <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### bench/can_rx_asserts.sv
// port checker of the CAN receive path
// assumes bind into can_receive_fifo_filter, one clock domain
`timescale 1ns/1ps
`default_nettype none
module can_rx_asserts (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  input  wire logic [7:0] rdata,
  input  wire logic       rx_frame_end,
  input  wire logic       power_down,
  input  wire logic [7:0] rx_err_count,
  input  wire logic [7:0] tx_err_count,
  input  wire logic       can_transmit_pin,
  input  wire logic       rx_irq,
  input  wire logic       overrun_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic       init_q;
  logic       ack_q;
  logic       pat_ok;
  logic [7:0] pat_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      init_q <= 1'b1;
      ack_q  <= 1'b0;
    end else begin
      ack_q <= init_q;
      if (wr && addr == can_rx_pkg::OFS_CTL0) begin
        init_q <= wdata[0];
      end
    end
  end
  // writes near an init edge are ambiguous, so they end the shadow check
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pat_q  <= can_rx_pkg::REG_RST;
      pat_ok <= 1'b1;
    end else if (wr && addr == can_rx_pkg::OFS_PAT) begin
      if (init_q && ack_q) begin
        pat_q <= wdata;
      end else if (init_q || ack_q) begin
        pat_ok <= 1'b0;
      end
    end
  end
  pin_down_a: assert property (power_down |=> can_transmit_pin)
    else $error("transmit pin dominant in power-down");
  pin_init_a: assert property (wr && addr == can_rx_pkg::OFS_CTL0 && wdata[0] |-> ##[1:2] can_transmit_pin)
    else $error("transmit pin dominant after init request");
  rxerr_read_a: assert property (rd && addr == can_rx_pkg::OFS_RXERR |=> rdata == $past(rx_err_count))
    else $error("receive error count altered");
  txerr_read_a: assert property (rd && addr == can_rx_pkg::OFS_TXERR |=> rdata == $past(tx_err_count))
    else $error("transmit error count altered");
  pat_lock_a: assert property (rd && addr == can_rx_pkg::OFS_PAT && pat_ok |=> rdata == pat_q)
    else $error("pattern byte changed outside init");
  irq_cause_a: assert property ($rose(rx_irq) |-> $past(rx_frame_end, 2) || $past(rx_frame_end, 4) || $past(wr, 2))
    else $error("receive irq without frame end");
  ovr_cause_a: assert property ($rose(overrun_irq) |-> $past(rx_frame_end, 2) || $past(rx_frame_end, 4) || $past(wr, 2))
    else $error("overrun irq without frame end");
  irq_hold_a: assert property ($fell(rx_irq) |-> $past(wr, 2))
    else $error("receive irq dropped without a write");
  ovr_clear_a: assert property (wr && addr == can_rx_pkg::OFS_RFLG && wdata[1] && !rx_frame_end |-> ##2 !overrun_irq)
    else $error("overrun irq not cleared");
  cover property ($rose(rx_irq));
  cover property ($rose(overrun_irq));
  cover property (power_down ##1 can_transmit_pin);
endmodule
bind can_receive_fifo_filter can_rx_asserts chk_i (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .rx_frame_end(rx_frame_end), .power_down(power_down), .rx_err_count(rx_err_count),
  .tx_err_count(tx_err_count), .can_transmit_pin(can_transmit_pin), .rx_irq(rx_irq), .overrun_irq(overrun_irq));
`default_nettype wire

// ### bench/can_receive_fifo_filter_tb_top.sv
// self-checking bench of the CAN receive path
// assumes can_frame_source stands in for the protocol engine
`timescale 1ns/1ps
`default_nettype none
module can_receive_fifo_filter_tb_top;
  logic       clk, rst_b, wr, rd, power_down;
  logic [7:0] addr, wdata, rdata, v, bd;
  logic       fs, bv, fe, fo, txa, al, pin, ack_en, rx_irq, ovr_irq, tick;
  logic [3:0] bi;
  int         error_cnt, checked;

  can_frame_source src (.clk(clk), .rx_frame_start(fs), .rx_byte_valid(bv), .rx_byte_index(bi),
    .rx_byte_data(bd), .rx_frame_end(fe), .rx_frame_ok(fo), .tx_active(txa), .arb_lost(al));
  can_receive_fifo_filter dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rx_frame_start(fs), .rx_byte_valid(bv), .rx_byte_index(bi), .rx_byte_data(bd),
    .rx_frame_end(fe), .rx_frame_ok(fo), .tx_active(txa), .arb_lost(al), .tx_bit(1'b0), .bit_tick(tick),
    .power_down(power_down), .special_mode(1'b0), .rx_err_count(8'h5A), .tx_err_count(8'hC3),
    .can_transmit_pin(pin), .rx_ack_enable(ack_en), .rx_irq(rx_irq), .overrun_irq(ovr_irq));

  always #20 clk = ~clk;

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic setup(input logic [1:0] mode, input logic [63:0] pat, input logic [63:0] msk, input logic [7:0] c1);
    int k;
    wreg(can_rx_pkg::OFS_CTL0, 8'h01);
    repeat (3) @(posedge clk);
    wreg(can_rx_pkg::OFS_CTL1, c1);
    for (k = 0; k < 8; k++) begin
      wreg(can_rx_pkg::OFS_PAT + k[7:0], pat[8*k +: 8]);
      wreg(can_rx_pkg::OFS_MASK + k[7:0], msk[8*k +: 8]);
    end
    wreg(can_rx_pkg::OFS_IDAC, {2'b00, mode, 4'h0});
    wreg(can_rx_pkg::OFS_RIER, 8'h03);
    wreg(can_rx_pkg::OFS_CTL0, 8'h00);
    repeat (3) @(posedge clk);
  endtask
  // check the foreground's first byte and hit index, then release it
  task automatic pop(input logic [7:0] b0, input logic [2:0] hit);
    rreg(can_rx_pkg::OFS_FG);
    chk(v, b0);
    rreg(can_rx_pkg::OFS_IDAC);
    chk({5'h00, v[2:0]}, {5'h00, hit});
    wreg(can_rx_pkg::OFS_RFLG, 8'h01);
  endtask
  task automatic s_lock();
    wreg(can_rx_pkg::OFS_PAT, 8'hFF);
    rreg(can_rx_pkg::OFS_PAT);
    chk(v, 8'h11);
    chk({7'h00, ack_en}, 8'h01);
    wreg(can_rx_pkg::OFS_RXERR, 8'h00);
    rreg(can_rx_pkg::OFS_RXERR);
    chk(v, 8'h5A);
    wreg(can_rx_pkg::OFS_TXERR, 8'h00);
    rreg(can_rx_pkg::OFS_TXERR);
    chk(v, 8'hC3);
    wreg(can_rx_pkg::OFS_CTL1, 8'h00);
    rreg(can_rx_pkg::OFS_CTL1);
    chk(v, 8'h80);
    rreg(8'h2F);
    chk(v, 8'h00);
  endtask
  task automatic s_fifo();
    int k;
    src.send(32'h4433_2211, 1'b1, 1'b0, 1'b0);
    src.send(32'h0000_0021, 1'b1, 1'b0, 1'b0);
    src.send(32'h4433_2211, 1'b0, 1'b0, 1'b0);
    src.send(32'h0000_0041, 1'b1, 1'b1, 1'b0);
    #1;
    chk({7'h00, ack_en}, 8'h00);
    src.send(32'h0000_0031, 1'b1, 1'b1, 1'b1);
    repeat (2) @(posedge clk);
    #1;
    chk({7'h00, rx_irq}, 8'h01);
    for (k = 0; k < 3; k++) begin
      src.send({24'h00_0000, 8'h51 + k[7:0]}, 1'b1, 1'b0, 1'b0);
    end
    rreg(can_rx_pkg::OFS_RFLG);
    chk(v, 8'h03);
    chk({7'h00, ovr_irq}, 8'h01);
    wreg(can_rx_pkg::OFS_RFLG, 8'h02);
    pop(8'h11, 3'h0);
    src.send(32'h0000_0061, 1'b1, 1'b0, 1'b0);
    pop(8'h21, 3'h1);
    pop(8'h31, 3'h1);
    pop(8'h51, 3'h1);
    pop(8'h52, 3'h1);
    pop(8'h61, 3'h1);
    rreg(can_rx_pkg::OFS_RFLG);
    chk(v, 8'h00);
    chk({7'h00, rx_irq}, 8'h00);
  endtask
  task automatic s_modes();
    int m;
    logic [7:0] hits [4] = '{8'hFF, 8'h01, 8'h02, 8'hFF};
    for (m = 0; m < 4; m++) begin
      setup(m[1:0], 64'h1716_1514_1312_1110, 64'h0000_0000_0000_0000, 8'hA0);
      // eight-filter pass also stamps: three bit ticks since init left
      if (m == 2) begin
        @(posedge clk);
        tick <= 1'b1;
        repeat (3) @(posedge clk);
        tick <= 1'b0;
        wreg(can_rx_pkg::OFS_CTL0, 8'h08);
      end
      src.send(32'h0000_1312, 1'b1, 1'b1, 1'b0);
      repeat (2) @(posedge clk);
      rreg(can_rx_pkg::OFS_RFLG);
      chk(v, {7'h00, hits[m] != 8'hFF});
      if (m == 2) begin
        rreg(can_rx_pkg::OFS_FG + 8'h0E);
        chk(v, 8'h03);
      end
      if (hits[m] != 8'hFF) begin
        pop(8'h12, hits[m][2:0]);
      end
    end
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    conclude();
  end
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    power_down = 1'b0;
    tick = 1'b0;
    error_cnt = 0;
    checked = 0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    rreg(can_rx_pkg::OFS_CTL0);
    chk(v, can_rx_pkg::CTL0_RST);
    rreg(can_rx_pkg::OFS_CTL1);
    chk(v, 8'h01);
    chk({7'h00, pin}, 8'h01);
    setup(can_rx_pkg::MODE_TWO, 64'h0000_0000_4433_2211, 64'hFFFF_FFFF_0000_0000, 8'h80);
    s_lock();
    s_fifo();
    chk({7'h00, pin}, 8'h00);
    @(posedge clk);
    power_down <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({7'h00, pin}, 8'h01);
    @(posedge clk);
    power_down <= 1'b0;
    s_modes();
    conclude();
  end
endmodule
`default_nettype wire
